// >>> shared/burst2_port_pkg.sv
// constants shared by the burst-of-two port and its helpers
`default_nettype none
package burst2_port_pkg;
	localparam int LANE_W = 9;
	localparam int WORD_DEFAULT = 36;
	localparam int BURST_LEN = 2;
	localparam int DEPTH_X36 = 2097152;
	localparam int DEPTH_X18 = 4194304;
	localparam int DEPTH_X9 = 8388608;
	localparam int STORE_AW_DEFAULT = 8;
	localparam int DLL_LOCK_CYCLES = 2048;
	localparam int DLL_CNT_W = 12;
	localparam int STOP_TIME_NS = 30;
	localparam int CORE_PERIOD_NS = 8;
	// least time rounds up
	localparam int STOP_CYCLES = (STOP_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int STOP_CNT_W = 4;
	localparam int STRAP_SETTLE = 3;
	localparam logic SYNC_RESET_LVL = 1'b1;
	localparam logic [3:0] EDGE_PREV_RESET = 4'hf;
	localparam logic DRIVE_OFF_N = 1'b1;
	localparam logic BEAT_FIRST = 1'b0;
	localparam logic BEAT_SECOND = 1'b1;

	function automatic int word_count(input int w);
		return (w == 36) ? DEPTH_X36 : (w == 18) ? DEPTH_X18 : DEPTH_X9;
	endfunction

	function automatic int addr_width(input int w);
		return $clog2(word_count(w) / BURST_LEN);
	endfunction
endpackage
`default_nettype wire

// >>> shared/port_bus_if.sv
// carrier between sampler, core and word store
`default_nettype none
interface port_bus_if #(
	parameter int DATA_W   = 36,
	parameter int ADDR_W   = 20,
	parameter int LANES    = 4,
	parameter int STORE_AW = 8
);
	logic                k_lvl;
	logic                kn_lvl;
	logic                c_lvl;
	logic                cn_lvl;
	logic                k_rise;
	logic                kn_rise;
	logic                c_rise;
	logic                cn_rise;
	logic                rd_sel_n;
	logic                wr_sel_n;
	logic                dll_off_n;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   wdata;
	logic [LANES-1:0]    be_n;
	logic                wr_en;
	logic [STORE_AW-1:0] wr_idx;
	logic [DATA_W-1:0]   wr_data;
	logic [LANES-1:0]    wr_be;
	logic [STORE_AW-1:0] rd_idx;
	logic [DATA_W-1:0]   rd_data;

	modport sampler (output k_lvl, kn_lvl, c_lvl, cn_lvl, k_rise, kn_rise, c_rise,
		cn_rise, rd_sel_n, wr_sel_n, dll_off_n, addr, wdata, be_n);
	modport core (input k_lvl, kn_lvl, c_lvl, cn_lvl, k_rise, kn_rise, c_rise,
		cn_rise, rd_sel_n, wr_sel_n, dll_off_n, addr, wdata, be_n, rd_data,
		output wr_en, wr_idx, wr_data, wr_be, rd_idx);
	modport store (input wr_en, wr_idx, wr_data, wr_be, rd_idx, output rd_data);
endinterface
`default_nettype wire

// >>> rtl/pin_sampler.sv
// two-flop synchronisers for all pins but core_clk and reset_n, edge finders for the four clock pins
`default_nettype none
module pin_sampler #(
	parameter int DATA_W = 36,
	parameter int ADDR_W = 20,
	parameter int LANES  = 4
) (
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	input  wire logic              k,
	input  wire logic              k_n,
	input  wire logic              c,
	input  wire logic              c_n,
	input  wire logic              rd_sel_n,
	input  wire logic              wr_sel_n,
	input  wire logic              dll_off_n,
	input  wire logic [ADDR_W-1:0] shared_addr,
	input  wire logic [DATA_W-1:0] write_data_in,
	input  wire logic [LANES-1:0]  byte_write_en_n,
	port_bus_if.sampler            bus
);
	localparam int VW = 7 + ADDR_W + DATA_W + LANES;

	logic [VW-1:0] raw;
	logic [VW-1:0] s1_q;
	logic [VW-1:0] s2_q;
	logic [3:0]    prev_q;

	assign raw = {k, k_n, c, c_n, rd_sel_n, wr_sel_n, dll_off_n,
		shared_addr, write_data_in, byte_write_en_n};

	// inactive-high reset keeps selects idle and hides false edges
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= {VW{burst2_port_pkg::SYNC_RESET_LVL}};
			s2_q <= {VW{burst2_port_pkg::SYNC_RESET_LVL}};
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= burst2_port_pkg::EDGE_PREV_RESET;
		end else begin
			prev_q <= s2_q[VW-1 -: 4];
		end
	end

	assign {bus.k_lvl, bus.kn_lvl, bus.c_lvl, bus.cn_lvl} = s2_q[VW-1 -: 4];
	assign {bus.k_rise, bus.kn_rise, bus.c_rise, bus.cn_rise} = s2_q[VW-1 -: 4] & ~prev_q;
	assign {bus.rd_sel_n, bus.wr_sel_n, bus.dll_off_n} = s2_q[VW-5 -: 3];
	assign {bus.addr, bus.wdata, bus.be_n} = s2_q[ADDR_W+DATA_W+LANES-1:0];
endmodule
`default_nettype wire

// >>> rtl/word_store.sv
// flip-flop word array with byte-lane writes
`default_nettype none
module word_store #(
	parameter int DATA_W   = 36,
	parameter int LANES    = 4,
	parameter int STORE_AW = 8
) (
	input  wire logic   core_clk,
	port_bus_if.store   bus
);
	localparam int LW = burst2_port_pkg::LANE_W;

	logic [DATA_W-1:0] mem_q [2**STORE_AW];

	always_ff @(posedge core_clk) begin
		if (bus.wr_en) begin
			for (int l = 0; l < LANES; l++) begin
				if (bus.wr_be[l]) begin
					mem_q[bus.wr_idx][l*LW +: LW] <= bus.wr_data[l*LW +: LW];
				end
			end
		end
	end

	assign bus.rd_data = mem_q[bus.rd_idx];
endmodule
`default_nettype wire

// >>> rtl/burst2_sram_port.sv
// burst-of-two separate-port sram, device side, sampled on core_clk
`default_nettype none
module burst2_sram_port #(
	parameter int DATA_W   = burst2_port_pkg::WORD_DEFAULT,
	parameter int STORE_AW = burst2_port_pkg::STORE_AW_DEFAULT,
	parameter int ADDR_W   = burst2_port_pkg::addr_width(DATA_W)
) (
	input  wire logic                core_clk,
	input  wire logic                reset_n,
	input  wire logic                k,
	input  wire logic                k_n,
	input  wire logic                c,
	input  wire logic                c_n,
	input  wire logic                rd_sel_n,
	input  wire logic                wr_sel_n,
	input  wire logic                dll_off_n,
	input  wire logic [ADDR_W-1:0]   shared_addr,
	input  wire logic [DATA_W-1:0]   write_data_in,
	input  wire logic [DATA_W/9-1:0] byte_write_en_n,
	output logic      [DATA_W-1:0]   read_data_out,
	output logic                     read_data_drive_n,
	output logic                     echo_clock,
	output logic                     echo_clock_n,
	output logic                     dll_locked
);
	localparam int LANES = DATA_W / burst2_port_pkg::LANE_W;
	localparam int IW = STORE_AW - 1;

	generate
		if (!(DATA_W == 36 || DATA_W == 18 || DATA_W == 9)) begin : g_bad_w
			$error("data width must be 9, 18 or 36");
		end
		if (STORE_AW < 2 || IW > ADDR_W) begin : g_bad_aw
			$error("store address width out of range");
		end
	endgenerate

	port_bus_if #(
		.DATA_W   (DATA_W),
		.ADDR_W   (ADDR_W),
		.LANES    (LANES),
		.STORE_AW (STORE_AW)
	) bus ();

	// every pin but core_clk and reset_n seen only through the sampler
	pin_sampler #(
		.DATA_W (DATA_W),
		.ADDR_W (ADDR_W),
		.LANES  (LANES)
	) u_sampler (
		.core_clk        (core_clk),
		.reset_n         (reset_n),
		.k               (k),
		.k_n             (k_n),
		.c               (c),
		.c_n             (c_n),
		.rd_sel_n        (rd_sel_n),
		.wr_sel_n        (wr_sel_n),
		.dll_off_n       (dll_off_n),
		.shared_addr     (shared_addr),
		.write_data_in   (write_data_in),
		.byte_write_en_n (byte_write_en_n),
		.bus             (bus.sampler)
	);

	word_store #(
		.DATA_W   (DATA_W),
		.LANES    (LANES),
		.STORE_AW (STORE_AW)
	) u_store (
		.core_clk (core_clk),
		.bus      (bus.store)
	);

	// burst counter: address plus fixed sequential beat bit
	function automatic logic [STORE_AW-1:0] make_idx(input logic [ADDR_W-1:0] a,
		input logic beat);
		return {a[IW-1:0], beat};
	endfunction

	// single clock strap
	logic [1:0] strap_cnt_q;
	logic       strap_done_q;
	logic       single_clk_q;

	// read path
	logic              rd_cap_q;
	logic [ADDR_W-1:0] rd_addr_q;
	logic              launch_vld_q;
	logic [ADDR_W-1:0] launch_addr_q;
	logic              sec_vld_q;
	logic [ADDR_W-1:0] sec_addr_q;
	logic              burst_done_q;
	logic [DATA_W-1:0] dout_q;
	logic              drive_n_q;

	// write path
	logic              wr_arm_q;
	logic [DATA_W-1:0] w0_data_q;
	logic [LANES-1:0]  w0_be_q;
	logic              w1_pend_q;
	logic [ADDR_W-1:0] w1_addr_q;
	logic [DATA_W-1:0] w1_data_q;
	logic [LANES-1:0]  w1_be_q;
	logic              w0_fire;

	localparam int DLL_W = burst2_port_pkg::DLL_CNT_W;
	localparam int SW = burst2_port_pkg::STOP_CNT_W;
	localparam logic [DLL_W-1:0] LOCK_N = DLL_W'(burst2_port_pkg::DLL_LOCK_CYCLES);
	localparam logic [SW-1:0] STOP_N = SW'(burst2_port_pkg::STOP_CYCLES);
	localparam logic [1:0] SETTLE_N = 2'(burst2_port_pkg::STRAP_SETTLE);

	// dll model and echo
	logic [DLL_W-1:0]  dll_cnt_q;
	logic              locked_q;
	logic [SW-1:0]     stop_cnt_q;
	logic              echo_q;
	logic              echo_n_q;

	logic out_p_rise;
	logic out_n_rise;

	// output reference picked from the strap
	assign out_p_rise = single_clk_q ? bus.k_rise : bus.c_rise;
	assign out_n_rise = single_clk_q ? bus.kn_rise : bus.cn_rise;

	// strap caught once, after synchronisers settle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_cnt_q  <= 2'h0;
			strap_done_q <= 1'b0;
			single_clk_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == SETTLE_N) begin
				strap_done_q <= 1'b1;
				single_clk_q <= bus.c_lvl & bus.cn_lvl;
			end
		end
	end

	// read command and address on input clock rise
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_cap_q  <= 1'b0;
			rd_addr_q <= '0;
		end else if (bus.k_rise) begin
			rd_cap_q <= ~bus.rd_sel_n;
			if (!bus.rd_sel_n) begin
				rd_addr_q <= bus.addr;
			end
		end else if (bus.kn_rise) begin
			rd_cap_q <= 1'b0;
		end
	end

	// read moves to launch at next input-bar rise
	// refill and consume may share a cycle
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			launch_vld_q  <= 1'b0;
			launch_addr_q <= '0;
		end else if (bus.kn_rise) begin
			launch_vld_q  <= rd_cap_q;
			launch_addr_q <= rd_addr_q;
		end else if (out_n_rise) begin
			launch_vld_q <= 1'b0;
		end
	end

	assign bus.rd_idx = out_n_rise ? make_idx(launch_addr_q, burst2_port_pkg::BEAT_FIRST)
		: make_idx(sec_addr_q, burst2_port_pkg::BEAT_SECOND);

	// word one on output-bar rise, word two on next output rise
	// release drive at next input rise after burst ends
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dout_q       <= '0;
			drive_n_q    <= burst2_port_pkg::DRIVE_OFF_N;
			sec_vld_q    <= 1'b0;
			sec_addr_q   <= '0;
			burst_done_q <= 1'b0;
		end else if (out_n_rise && launch_vld_q) begin
			dout_q       <= bus.rd_data;
			drive_n_q    <= 1'b0;
			sec_vld_q    <= 1'b1;
			sec_addr_q   <= launch_addr_q;
			burst_done_q <= 1'b0;
		end else if (out_p_rise && sec_vld_q) begin
			dout_q       <= bus.rd_data;
			sec_vld_q    <= 1'b0;
			burst_done_q <= 1'b1;
		end else if (bus.k_rise && burst_done_q) begin
			drive_n_q    <= burst2_port_pkg::DRIVE_OFF_N;
			burst_done_q <= 1'b0;
		end
	end

	// first write word with the select edge
	// data ignored unless write select low
	// byte enables inverted to active high
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_arm_q  <= 1'b0;
			w0_data_q <= '0;
			w0_be_q   <= '0;
		end else if (bus.k_rise) begin
			wr_arm_q <= ~bus.wr_sel_n;
			if (!bus.wr_sel_n) begin
				w0_data_q <= bus.wdata;
				w0_be_q   <= ~bus.be_n;
			end
		end else if (bus.kn_rise) begin
			wr_arm_q <= 1'b0;
		end
	end

	// second word on the same input-bar rise
	assign w0_fire = bus.kn_rise & wr_arm_q;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			w1_pend_q <= 1'b0;
			w1_addr_q <= '0;
			w1_data_q <= '0;
			w1_be_q   <= '0;
		end else if (w0_fire) begin
			w1_pend_q <= 1'b1;
			w1_addr_q <= bus.addr;
			w1_data_q <= bus.wdata;
			w1_be_q   <= ~bus.be_n;
		end else begin
			w1_pend_q <= 1'b0;
		end
	end

	// write port separate from read port
	// both commands proceed side by side
	assign bus.wr_en   = w0_fire | w1_pend_q;
	assign bus.wr_idx  = w0_fire ? make_idx(bus.addr, burst2_port_pkg::BEAT_FIRST)
		: make_idx(w1_addr_q, burst2_port_pkg::BEAT_SECOND);
	assign bus.wr_data = w0_fire ? w0_data_q : w1_data_q;
	assign bus.wr_be   = w0_fire ? w0_be_q : w1_be_q;

	// input clock stop watch, restarts the loop
	// either input edge counts, so a running clock is no stop while its edges come at most STOP_N cycles apart
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_cnt_q <= '0;
		end else if (bus.k_rise || bus.kn_rise) begin
			stop_cnt_q <= '0;
		end else if (stop_cnt_q != STOP_N) begin
			stop_cnt_q <= stop_cnt_q + SW'(1);
		end
	end

	// loop bypassed while disable low; lock counted otherwise
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dll_cnt_q <= '0;
			locked_q  <= 1'b0;
		end else if (!bus.dll_off_n || stop_cnt_q == STOP_N) begin
			dll_cnt_q <= '0;
			locked_q  <= 1'b0;
		end else if (bus.k_rise && !locked_q) begin
			dll_cnt_q <= dll_cnt_q + DLL_W'(1);
			locked_q  <= (dll_cnt_q == LOCK_N - DLL_W'(1));
		end
	end

	// echo pair follows the output reference
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			echo_q   <= 1'b0;
			echo_n_q <= 1'b1;
		end else begin
			echo_q   <= single_clk_q ? bus.k_lvl : bus.c_lvl;
			echo_n_q <= single_clk_q ? bus.kn_lvl : bus.cn_lvl;
		end
	end

	assign read_data_out     = dout_q;
	assign read_data_drive_n = drive_n_q;
	assign echo_clock        = echo_q;
	assign echo_clock_n      = echo_n_q;
	assign dll_locked        = locked_q;
endmodule
`default_nettype wire

// >>> testbench/burst2_port_sva.sv
// pin assertions for the burst-of-two port
`default_nettype none
module burst2_port_sva #(
	parameter int DATA_W = 36
) (
	input wire logic              core_clk,
	input wire logic              reset_n,
	input wire logic              k,
	input wire logic              rd_sel_n,
	input wire logic              dll_off_n,
	input wire logic [DATA_W-1:0] read_data_out,
	input wire logic              read_data_drive_n,
	input wire logic              echo_clock,
	input wire logic              echo_clock_n,
	input wire logic              dll_locked
);
	logic [3:0]  up_q;
	logic [5:0]  rd_age_q;
	logic [14:0] on_age_q;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// settle time until the clock-mode strap is taken
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			up_q <= 4'h0;
		end else if (up_q != 4'hf) begin
			up_q <= up_q + 4'h1;
		end
	end

	// cycles since read select was last low
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_age_q <= 6'h3f;
		end else if (!rd_sel_n) begin
			rd_age_q <= 6'h0;
		end else if (rd_age_q != 6'h3f) begin
			rd_age_q <= rd_age_q + 6'h1;
		end
	end

	// cycles with the loop enabled
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			on_age_q <= 15'h0;
		end else if (!dll_off_n) begin
			on_age_q <= 15'h0;
		end else if (on_age_q != 15'h7fff) begin
			on_age_q <= on_age_q + 15'h1;
		end
	end

	a_echo_pair: assert property (up_q == 4'hf |-> echo_clock != echo_clock_n)
		else $error("echo clocks not complementary");
	a_echo_from_k: assert property (up_q == 4'hf && $rose(k) |-> ##[1:5] echo_clock)
		else $error("echo clock does not follow input clock");
	a_idle_float: assert property (rd_age_q == 6'h3f |-> read_data_drive_n)
		else $error("outputs driven long after last read");
	a_drive_cause: assert property ($fell(read_data_drive_n) |-> rd_age_q <= 6'hb)
		else $error("outputs driven without a read");
	a_burst_len: assert property ($fell(read_data_drive_n) |-> (!read_data_drive_n) [*8])
		else $error("burst shorter than two words");
	a_word_hold: assert property (!read_data_drive_n && $changed(read_data_out)
		|=> $stable(read_data_out) [*3])
		else $error("read word held under half a period");
	a_dll_bypass: assert property ((!dll_off_n) [*4] |=> !dll_locked)
		else $error("lock shown while loop disabled");
	a_lock_wait: assert property ($rose(dll_locked) |-> on_age_q >= 15'h3e80)
		else $error("lock shown too early");
endmodule

bind burst2_sram_port burst2_port_sva #(.DATA_W(DATA_W)) u_sva (
	.core_clk          (core_clk),
	.reset_n           (reset_n),
	.k                 (k),
	.rd_sel_n          (rd_sel_n),
	.dll_off_n         (dll_off_n),
	.read_data_out     (read_data_out),
	.read_data_drive_n (read_data_drive_n),
	.echo_clock        (echo_clock),
	.echo_clock_n      (echo_clock_n),
	.dll_locked        (dll_locked)
);
`default_nettype wire

// >>> testbench/host_clock_model.sv
// host clock source: free input pair, output pair parked high or trailing it
`default_nettype none
module host_clock_model #(
	parameter int HALF_NS = 32,
	parameter int SKEW_NS = 10
) (
	input  wire logic c_run,
	output var logic  k,
	output var logic  k_n,
	output var logic  c,
	output var logic  c_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// both output clocks high selects single clock mode
	// once running, the output pair trails the input pair by the skew
	initial begin
		c = 1'b1;
		c_n = 1'b1;
		forever begin
			@(k);
			#SKEW_NS;
			c = c_run ? k : 1'b1;
			c_n = c_run ? k_n : 1'b1;
		end
	end
	// input pair is the only reference, phase off the core clock
	initial begin
		k = 1'b0;
		k_n = 1'b1;
		#13;
		forever begin
			#HALF_NS;
			k = ~k;
			k_n = ~k_n;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/burst2_sram_port_bench.sv
// self-checking bench for the burst-of-two port
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module burst2_sram_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DW = 18;
	localparam int SAW = 4;
	localparam int AW = burst2_port_pkg::addr_width(DW);
	localparam int LN = DW / 9;
	localparam int LIMIT = 40000;
	logic          core_clk;
	logic          reset_n;
	logic          k;
	logic          k_n;
	logic          c;
	logic          c_n;
	logic          c_run;
	logic          rd_sel_n;
	logic          wr_sel_n;
	logic          dll_off_n;
	logic [AW-1:0] shared_addr;
	logic [DW-1:0] write_data_in;
	logic [LN-1:0] byte_write_en_n;
	logic [DW-1:0] read_data_out;
	logic          read_data_drive_n;
	logic          echo_clock;
	logic          echo_clock_n;
	logic          dll_locked;
	logic          kp = 1'b0;
	int            cyc = 0;
	int            mismatches = 0;
	int            total_checks = 0;
	int            rd_lat1 = 17;
	int            rd_lat2 = 21;
	int            due_q[$];
	logic [DW-1:0] exp_q[$];
	logic [DW-1:0] mem[16];

	host_clock_model u_host (
		.c_run (c_run),
		.k     (k),
		.k_n   (k_n),
		.c     (c),
		.c_n   (c_n)
	);

	burst2_sram_port #(.DATA_W(DW), .STORE_AW(SAW)) dut (
		.core_clk          (core_clk),
		.reset_n           (reset_n),
		.k                 (k),
		.k_n               (k_n),
		.c                 (c),
		.c_n               (c_n),
		.rd_sel_n          (rd_sel_n),
		.wr_sel_n          (wr_sel_n),
		.dll_off_n         (dll_off_n),
		.shared_addr       (shared_addr),
		.write_data_in     (write_data_in),
		.byte_write_en_n   (byte_write_en_n),
		.read_data_out     (read_data_out),
		.read_data_drive_n (read_data_drive_n),
		.echo_clock        (echo_clock),
		.echo_clock_n      (echo_clock_n),
		.dll_locked        (dll_locked)
	);

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// one input clock period: command at k rise, write address at k_n rise
	task automatic period(input logic rd, input logic wr, input logic [2:0] ra,
		input logic [2:0] wa, input logic [LN-1:0] be1, input logic [LN-1:0] be2);
		logic [DW-1:0] w1;
		logic [DW-1:0] w2;
		logic [DW-1:0] e1;
		logic [DW-1:0] e2;
		int d;
		w1 = DW'($urandom());
		w2 = DW'($urandom());
		// active-low selects, read address at k rise
		rd_sel_n <= rd;
		wr_sel_n <= wr;
		shared_addr <= AW'({$urandom(), ra});
		write_data_in <= w1;
		byte_write_en_n <= be1;
		e1 = mem[{ra, 1'b0}];
		e2 = mem[{ra, 1'b1}];
		// one active-low enable per nine bits
		if (!wr) begin
			for (int l = 0; l < LN; l++) begin
				if (!be1[l]) mem[{wa, 1'b0}][9*l+:9] = w1[9*l+:9];
				if (!be2[l]) mem[{wa, 1'b1}][9*l+:9] = w2[9*l+:9];
			end
		end
		do @(posedge core_clk); while (!(k && !kp));
		d = cyc;
		if (!rd) begin
			due_q.push_back(d + rd_lat1);
			exp_q.push_back(e1);
			due_q.push_back(d + rd_lat2);
			exp_q.push_back(e2);
		end
		repeat (2) @(posedge core_clk);
		// write address and second word at k_n rise
		shared_addr <= AW'({$urandom(), wa});
		write_data_in <= w2;
		byte_write_en_n <= be2;
		repeat (4) @(posedge core_clk);
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		kp <= k;
		if (cyc == LIMIT) begin
			mismatches++;
			conclude();
		end
	end

	always @(negedge core_clk) begin
		if (due_q.size() != 0 && due_q[0] == cyc) begin
			`CHK(read_data_out, exp_q[0])
			`CHK(read_data_drive_n, 1'b0)
			void'(due_q.pop_front());
			void'(exp_q.pop_front());
		end
	end

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	initial begin
		reset_n = 1'b0;
		c_run = 1'b0;
		rd_sel_n = 1'b1;
		wr_sel_n = 1'b1;
		dll_off_n = 1'b1;
		shared_addr = '0;
		write_data_in = '0;
		byte_write_en_n = '1;
		void'($urandom(6));
		repeat (3) @(posedge core_clk);
		`CHK(read_data_drive_n, 1'b1)
		`CHK(dll_locked, 1'b0)
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		period(1'b1, 1'b1, 3'h0, 3'h0, '1, '1);
		for (int i = 0; i < 8; i++) period(1'b1, 1'b0, 3'h0, 3'(i), '0, '0);
		for (int i = 0; i < 8; i++) period(1'b1, 1'b0, 3'h0, 3'(i), LN'($urandom()), '1);
		// data with write select high is ignored
		repeat (2) period(1'b1, 1'b1, 3'h0, 3'h0, '0, '0);
		// reads every period with writes beside them
		for (int i = 0; i < 8; i++) period(1'b0, 1'b0, 3'(i), 3'(i + 4), LN'($urandom()), '0);
		repeat (4) period(1'b1, 1'b1, 3'h0, 3'h0, '1, '1);
		`CHK(read_data_drive_n, 1'b1)
		`CHK(due_q.size(), 0)
		repeat (2) begin
			period(1'b0, 1'b1, 3'($urandom()), 3'h0, '1, '1);
			repeat (4) period(1'b1, 1'b1, 3'h0, 3'h0, '1, '1);
			`CHK(read_data_drive_n, 1'b1)
		end
		for (int i = 0; i < 20000 && dll_locked !== 1'b1; i++) @(posedge core_clk);
		`CHK(dll_locked, 1'b1)
		dll_off_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		`CHK(dll_locked, 1'b0)
		dll_off_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		// second reset with the output clock pair running
		reset_n <= 1'b0;
		c_run <= 1'b1;
		repeat (5) @(posedge core_clk);
		`CHK(read_data_drive_n, 1'b1)
		reset_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		// output pair trails the input pair slightly: words come a whole input period less one cycle (7 cycles) sooner
		rd_lat1 = 9;
		rd_lat2 = 13;
		period(1'b0, 1'b1, 3'h5, 3'h0, '1, '1);
		period(1'b0, 1'b1, 3'h6, 3'h0, '1, '1);
		repeat (4) period(1'b1, 1'b1, 3'h0, 3'h0, '1, '1);
		`CHK(read_data_drive_n, 1'b1)
		`CHK(due_q.size(), 0)
		conclude();
	end
endmodule
`default_nettype wire
